/* File: logic/acsr_defines.vh */
// Purpose: constants for the converter status and result register block
// Assumes: byte-wide special-function-register port, one core clock
// Notes: addresses other than status and operation are local choices
//
// Behaviour
// RULE1 - primary ready flag, status bit 7, sets when conversion or calibration ends
// RULE2 - primary ready clears by direct write or by writing a calibration code
// RULE3 - while primary ready is set, results and coefficients are not overwritten
// RULE4 - status bit 6 is the auxiliary ready flag, same behaviour as primary
// RULE5 - calibration-done flag, status bit 5, sets when a calibration completes
// RULE6 - calibration-done clears when software starts a conversion or calibration
// RULE7 - auxiliary calibration with temperature sensor selected never completes
// RULE8 - status bit 4 shows a missing reference while either converter runs
// RULE9 - with reference missing, every stored result is forced to all ones
// RULE10 - status bit 3 sets when the primary result written is saturated
// RULE11 - after calibration, bit 3 flags a fault that blocked coefficient update
// RULE12 - primary error flag clears when software starts conversion or calibration
// RULE13 - status bit 2 is the auxiliary error flag, same behaviour as primary
// RULE14 - status bits 1 and 0 are unimplemented, writes ignored, read zero
// RULE15 - primary result is 24 bits over three bytes, low byte absent on 16-bit
// RULE16 - primary offset coefficient is 24 bits over three bytes
// RULE17 - primary gain coefficient is 24 bits over three bytes
// RULE18 - auxiliary offset coefficient is 16 bits over low and high bytes
// RULE19 - auxiliary gain coefficient is 16 bits over low and high bytes
// RULE20 - auxiliary result is 24 bits in its own byte registers
// RULE21 - decimation-factor register sets the filter ratio for both converters
// RULE22 - software requests system zero-scale with code 110, full-scale with 111
// RULE23 - clearing primary enable powers it down, setting it starts the operation
// RULE24 - a hardware flag set beats a software write in the same cycle
`ifndef ACSR_DEFINES_VH
`define ACSR_DEFINES_VH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define ACSR_ADDR_STATUS 8'hd8
`define ACSR_ADDR_OPER 8'hd1
`define ACSR_ADDR_AUX_CTL 8'hd2
`define ACSR_ADDR_DECIM 8'hd4
`define ACSR_ADDR_PRI_RES_L 8'hd9
`define ACSR_ADDR_PRI_RES_M 8'hda
`define ACSR_ADDR_PRI_RES_H 8'hdb
`define ACSR_ADDR_AUX_RES_L 8'hdc
`define ACSR_ADDR_AUX_RES_M 8'hdd
`define ACSR_ADDR_AUX_RES_H 8'hde
`define ACSR_ADDR_PRI_OFF_L 8'he1
`define ACSR_ADDR_PRI_OFF_M 8'he2
`define ACSR_ADDR_PRI_OFF_H 8'he3
`define ACSR_ADDR_PRI_GN_L 8'he4
`define ACSR_ADDR_PRI_GN_M 8'he5
`define ACSR_ADDR_PRI_GN_H 8'he6
`define ACSR_ADDR_AUX_OFF_L 8'he9
`define ACSR_ADDR_AUX_OFF_H 8'hea
`define ACSR_ADDR_AUX_GN_L 8'heb
`define ACSR_ADDR_AUX_GN_H 8'hec

// ----------------------------------------
// status bit positions
// ----------------------------------------
`define ACSR_BIT_PRI_RDY 7
`define ACSR_BIT_AUX_RDY 6
`define ACSR_BIT_CAL 5
`define ACSR_BIT_NOREF 4
`define ACSR_BIT_PRI_ERR 3
`define ACSR_BIT_AUX_ERR 2

// ----------------------------------------
// operation and auxiliary control register fields and codes
// ----------------------------------------
`define ACSR_BIT_PRI_ON 5
`define ACSR_BIT_AUX_ON 4
`define ACSR_BIT_CHOP_OFF 3
`define ACSR_OP_MSB 2
`define ACSR_OP_LSB 0
`define ACSR_OP_PWRDN 3'h0
`define ACSR_OP_IDLE 3'h1
`define ACSR_OP_SINGLE 3'h2
`define ACSR_OP_CONT 3'h3
`define ACSR_OP_INT_ZERO 3'h4
`define ACSR_OP_INT_FULL 3'h5
`define ACSR_OP_SYS_ZERO 3'h6
`define ACSR_OP_SYS_FULL 3'h7
`define ACSR_AUX_CH_MSB 5
`define ACSR_AUX_CH_LSB 4
`define ACSR_AUX_CH_TEMP 2'h2

// ----------------------------------------
// reset values
// ----------------------------------------
`define ACSR_RST_STATUS 8'h00
`define ACSR_RST_OPER 8'h08
`define ACSR_RST_AUX_CTL 8'h00
`define ACSR_RST_DECIM 8'h45
`define ACSR_RST_BYTE 8'h00

`endif

/* File: logic/acsr_conv_store.v */
// Purpose: result and calibration coefficient storage for one converter
// Assumes: completion strobes are one-cycle pulses on the core clock
// Notes: combinational take/saturation outputs feed the status flags

`timescale 1ns/1ns

module acsr_conv_store
#(
  parameter RES_W = 24,
  parameter COEF_W = 24
)
(
  // clock and reset
  input wire sys_clk_i,
  input wire reset_n_i,
  input wire ce_i,
  // flag state
  input wire ready_i,
  input wire ref_missing_i,
  // conversion and calibration results
  input wire conv_done_i,
  input wire [RES_W-1:0] conv_data_i,
  input wire cal_done_i,
  input wire cal_ok_i,
  input wire cal_gain_i,
  input wire [COEF_W-1:0] cal_coeff_i,
  // stored values and events
  output reg [RES_W-1:0] result_o,
  output reg [COEF_W-1:0] offset_o,
  output reg [COEF_W-1:0] gain_o,
  output wire res_take_o,
  output wire res_sat_o,
  output wire cal_take_o
);

  wire [RES_W-1:0] res_value;

  // missing reference clamps the written value
  assign res_value = ref_missing_i ? {RES_W{1'b1}} : conv_data_i; // RULE9
  // nothing is written while the ready flag stands
  assign res_take_o = conv_done_i & ~ready_i; // RULE3
  assign cal_take_o = cal_done_i & ~ready_i; // RULE3
  assign res_sat_o = (res_value == {RES_W{1'b1}}) | (res_value == {RES_W{1'b0}});

  always @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      result_o <= {RES_W{1'b0}};
      offset_o <= {COEF_W{1'b0}};
      gain_o <= {COEF_W{1'b0}};
    end
    else if (ce_i)
    begin
      if (res_take_o)
      begin
        result_o <= res_value;
      end
      // a failed calibration leaves the coefficients untouched
      if (cal_take_o && cal_ok_i && !cal_gain_i)
      begin
        offset_o <= cal_coeff_i; // RULE11
      end
      if (cal_take_o && cal_ok_i && cal_gain_i)
      begin
        gain_o <= cal_coeff_i; // RULE11
      end
    end
  end

endmodule

/* File: logic/acsr_status_regs.v */
// Purpose: status flags, operation control and result byte registers
// Assumes: byte register port on the core clock, read data one cycle late
// Notes: converter datapath sits outside and reports completions here

`timescale 1ns/1ns

`include "acsr_defines.vh"

module acsr_status_regs
#(
  parameter PRI_HAS_LOW = 1,
  parameter PRI_W = 24,
  parameter AUX_W = 24,
  parameter AUX_COEF_W = 16
)
(
  // clock, reset, enable
  input wire sys_clk_i,
  input wire reset_n_i,
  input wire ce_i,
  // register port from the core
  input wire [7:0] sfr_addr_i,
  input wire sfr_wr_i,
  input wire [7:0] sfr_wdata_i,
  input wire sfr_rd_i,
  output reg [7:0] sfr_rdata_o,
  // reference detector, asynchronous
  input wire ref_missing_i,
  // primary converter completions
  input wire pri_conv_done_i,
  input wire [PRI_W-1:0] pri_conv_data_i,
  input wire pri_cal_done_i,
  input wire pri_cal_ok_i,
  input wire pri_cal_gain_i,
  input wire [PRI_W-1:0] pri_cal_coeff_i,
  // auxiliary converter completions
  input wire aux_conv_done_i,
  input wire [AUX_W-1:0] aux_conv_data_i,
  input wire aux_cal_done_i,
  input wire aux_cal_ok_i,
  input wire aux_cal_gain_i,
  input wire [AUX_COEF_W-1:0] aux_cal_coeff_i,
  // control towards the converters
  output reg pri_enable_o,
  output reg aux_enable_o,
  output reg pri_start_o,
  output reg aux_start_o,
  output reg chop_off_o,
  output reg [2:0] operation_select_o,
  output reg [7:0] decimation_o,
  output reg [7:0] aux_control_o,
  output reg [7:0] converter_status_o
);

  // ----------------------------------------
  // reference input synchroniser
  // ----------------------------------------
  reg ref_s1;
  reg ref_s2;
  reg ref_s3;
  reg ref_missing;

  always @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ref_s1 <= 1'b0;
      ref_s2 <= 1'b0;
      ref_s3 <= 1'b0;
      ref_missing <= 1'b0;
    end
    else if (ce_i)
    begin
      ref_s1 <= ref_missing_i;
      ref_s2 <= ref_s1;
      ref_s3 <= ref_s2;
      // a change counts only once the last two stages agree
      if (ref_s2 == ref_s3)
      begin
        ref_missing <= ref_s3;
      end
    end
  end

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  wire wr_status;
  wire wr_oper;
  wire wr_aux_ctl;
  wire wr_decim;
  wire [2:0] wr_op_code;
  wire op_is_cal;
  wire op_starts;

  assign wr_status = sfr_wr_i & (sfr_addr_i == `ACSR_ADDR_STATUS);
  assign wr_oper = sfr_wr_i & (sfr_addr_i == `ACSR_ADDR_OPER);
  assign wr_aux_ctl = sfr_wr_i & (sfr_addr_i == `ACSR_ADDR_AUX_CTL);
  assign wr_decim = sfr_wr_i & (sfr_addr_i == `ACSR_ADDR_DECIM);
  assign wr_op_code = sfr_wdata_i[`ACSR_OP_MSB:`ACSR_OP_LSB];
  // codes 1xx are calibrations, including system zero and full scale
  assign op_is_cal = wr_oper & wr_op_code[2]; // RULE22
  assign op_starts = wr_oper & (wr_op_code[2] | wr_op_code[1]);

  reg [7:0] oper_reg;

  always @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      oper_reg <= `ACSR_RST_OPER;
      aux_control_o <= `ACSR_RST_AUX_CTL;
      decimation_o <= `ACSR_RST_DECIM;
      pri_enable_o <= 1'b0;
      aux_enable_o <= 1'b0;
      pri_start_o <= 1'b0;
      aux_start_o <= 1'b0;
      chop_off_o <= 1'b1;
      operation_select_o <= `ACSR_OP_PWRDN;
    end
    else if (ce_i)
    begin
      if (wr_oper)
      begin
        oper_reg <= sfr_wdata_i;
      end
      if (wr_aux_ctl)
      begin
        aux_control_o <= sfr_wdata_i;
      end
      if (wr_decim)
      begin
        decimation_o <= sfr_wdata_i; // RULE21
      end
      // enable low means power-down, enable high runs the selected mode
      pri_enable_o <= wr_oper ? sfr_wdata_i[`ACSR_BIT_PRI_ON] : oper_reg[`ACSR_BIT_PRI_ON]; // RULE23
      aux_enable_o <= wr_oper ? sfr_wdata_i[`ACSR_BIT_AUX_ON] : oper_reg[`ACSR_BIT_AUX_ON];
      chop_off_o <= wr_oper ? sfr_wdata_i[`ACSR_BIT_CHOP_OFF] : oper_reg[`ACSR_BIT_CHOP_OFF];
      operation_select_o <= wr_oper ? wr_op_code : oper_reg[`ACSR_OP_MSB:`ACSR_OP_LSB];
      pri_start_o <= wr_oper & sfr_wdata_i[`ACSR_BIT_PRI_ON]; // RULE23
      aux_start_o <= wr_oper & sfr_wdata_i[`ACSR_BIT_AUX_ON];
    end
  end

  // ----------------------------------------
  // converter storage
  // ----------------------------------------
  reg pri_ready;
  reg aux_ready;
  wire aux_temp_sel;
  wire aux_cal_done;
  wire [PRI_W-1:0] pri_result;
  wire [PRI_W-1:0] pri_offset;
  wire [PRI_W-1:0] pri_gain;
  wire [AUX_W-1:0] aux_result;
  wire [AUX_COEF_W-1:0] aux_offset;
  wire [AUX_COEF_W-1:0] aux_gain;
  wire pri_res_take;
  wire pri_res_sat;
  wire pri_cal_take;
  wire aux_res_take;
  wire aux_res_sat;
  wire aux_cal_take;

  assign aux_temp_sel = aux_control_o[`ACSR_AUX_CH_MSB:`ACSR_AUX_CH_LSB] == `ACSR_AUX_CH_TEMP;
  // the temperature channel cannot be calibrated: the completion is dropped
  assign aux_cal_done = aux_cal_done_i & ~aux_temp_sel; // RULE7

  acsr_conv_store
  #(
    .RES_W(PRI_W),
    .COEF_W(PRI_W)
  )
  u_pri_store
  (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .ready_i(pri_ready),
    .ref_missing_i(ref_missing),
    .conv_done_i(pri_conv_done_i),
    .conv_data_i(pri_conv_data_i),
    .cal_done_i(pri_cal_done_i),
    .cal_ok_i(pri_cal_ok_i),
    .cal_gain_i(pri_cal_gain_i),
    .cal_coeff_i(pri_cal_coeff_i),
    .result_o(pri_result),
    .offset_o(pri_offset),
    .gain_o(pri_gain),
    .res_take_o(pri_res_take),
    .res_sat_o(pri_res_sat),
    .cal_take_o(pri_cal_take)
  );

  acsr_conv_store
  #(
    .RES_W(AUX_W),
    .COEF_W(AUX_COEF_W)
  )
  u_aux_store
  (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .ready_i(aux_ready),
    .ref_missing_i(ref_missing),
    .conv_done_i(aux_conv_done_i),
    .conv_data_i(aux_conv_data_i),
    .cal_done_i(aux_cal_done),
    .cal_ok_i(aux_cal_ok_i),
    .cal_gain_i(aux_cal_gain_i),
    .cal_coeff_i(aux_cal_coeff_i),
    .result_o(aux_result),
    .offset_o(aux_offset),
    .gain_o(aux_gain),
    .res_take_o(aux_res_take),
    .res_sat_o(aux_res_sat),
    .cal_take_o(aux_cal_take)
  );

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  reg cal_flag;
  reg pri_err;
  reg aux_err;
  reg noref_flag;
  wire pri_rdy_set;
  wire aux_rdy_set;
  wire cal_set;
  wire pri_err_set;
  wire aux_err_set;
  wire conv_active;

  assign pri_rdy_set = pri_res_take | pri_cal_take; // RULE1
  assign aux_rdy_set = aux_res_take | aux_cal_take; // RULE4
  assign cal_set = pri_cal_take | aux_cal_take; // RULE5
  assign pri_err_set = (pri_res_take & pri_res_sat) | (pri_cal_take & ~pri_cal_ok_i); // RULE10 RULE11
  assign aux_err_set = (aux_res_take & aux_res_sat) | (aux_cal_take & ~aux_cal_ok_i); // RULE13
  assign conv_active = oper_reg[`ACSR_BIT_PRI_ON] | oper_reg[`ACSR_BIT_AUX_ON];

  always @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pri_ready <= 1'b0;
      aux_ready <= 1'b0;
      cal_flag <= 1'b0;
      pri_err <= 1'b0;
      aux_err <= 1'b0;
      noref_flag <= 1'b0;
    end
    else if (ce_i)
    begin
      // hardware set is checked first so a write never drops a completion taken while the flag is clear
      if (pri_rdy_set)
      begin
        pri_ready <= 1'b1; // RULE24
      end
      else if (wr_status)
      begin
        pri_ready <= sfr_wdata_i[`ACSR_BIT_PRI_RDY]; // RULE2
      end
      else if (op_is_cal)
      begin
        pri_ready <= 1'b0; // RULE2
      end
      if (aux_rdy_set)
      begin
        aux_ready <= 1'b1; // RULE24
      end
      else if (wr_status)
      begin
        aux_ready <= sfr_wdata_i[`ACSR_BIT_AUX_RDY]; // RULE4
      end
      else if (op_is_cal)
      begin
        aux_ready <= 1'b0; // RULE4
      end
      if (cal_set)
      begin
        cal_flag <= 1'b1; // RULE24
      end
      else if (op_starts)
      begin
        cal_flag <= 1'b0; // RULE6
      end
      if (pri_err_set)
      begin
        pri_err <= 1'b1; // RULE24
      end
      else if (op_starts)
      begin
        pri_err <= 1'b0; // RULE12
      end
      if (aux_err_set)
      begin
        aux_err <= 1'b1; // RULE24
      end
      else if (op_starts)
      begin
        aux_err <= 1'b0; // RULE13
      end
      noref_flag <= ref_missing & conv_active; // RULE8
    end
  end

  // bits 1 and 0 have no storage and read zero
  wire [7:0] status_value;

  assign status_value = {pri_ready, aux_ready, cal_flag, noref_flag, pri_err, aux_err, 2'h0}; // RULE14

  // ----------------------------------------
  // read path
  // ----------------------------------------
  reg [7:0] next_rdata;
  wire [7:0] pri_res_l;
  wire [7:0] pri_off_l;
  wire [7:0] pri_gn_l;

  // the narrow variant has no low byte; it reads as zero
  assign pri_res_l = (PRI_HAS_LOW != 0) ? pri_result[7:0] : `ACSR_RST_BYTE; // RULE15
  assign pri_off_l = (PRI_HAS_LOW != 0) ? pri_offset[7:0] : `ACSR_RST_BYTE; // RULE16
  assign pri_gn_l = (PRI_HAS_LOW != 0) ? pri_gain[7:0] : `ACSR_RST_BYTE; // RULE17

  always @*
  begin
    next_rdata = `ACSR_RST_BYTE;
    case (sfr_addr_i)
      `ACSR_ADDR_STATUS: next_rdata = status_value;
      `ACSR_ADDR_OPER: next_rdata = oper_reg;
      `ACSR_ADDR_AUX_CTL: next_rdata = aux_control_o;
      `ACSR_ADDR_DECIM: next_rdata = decimation_o;
      `ACSR_ADDR_PRI_RES_L: next_rdata = pri_res_l;
      `ACSR_ADDR_PRI_RES_M: next_rdata = pri_result[15:8]; // RULE15
      `ACSR_ADDR_PRI_RES_H: next_rdata = pri_result[23:16]; // RULE15
      `ACSR_ADDR_AUX_RES_L: next_rdata = aux_result[7:0]; // RULE20
      `ACSR_ADDR_AUX_RES_M: next_rdata = aux_result[15:8]; // RULE20
      `ACSR_ADDR_AUX_RES_H: next_rdata = aux_result[23:16]; // RULE20
      `ACSR_ADDR_PRI_OFF_L: next_rdata = pri_off_l;
      `ACSR_ADDR_PRI_OFF_M: next_rdata = pri_offset[15:8]; // RULE16
      `ACSR_ADDR_PRI_OFF_H: next_rdata = pri_offset[23:16]; // RULE16
      `ACSR_ADDR_PRI_GN_L: next_rdata = pri_gn_l;
      `ACSR_ADDR_PRI_GN_M: next_rdata = pri_gain[15:8]; // RULE17
      `ACSR_ADDR_PRI_GN_H: next_rdata = pri_gain[23:16]; // RULE17
      `ACSR_ADDR_AUX_OFF_L: next_rdata = aux_offset[7:0]; // RULE18
      `ACSR_ADDR_AUX_OFF_H: next_rdata = aux_offset[15:8]; // RULE18
      `ACSR_ADDR_AUX_GN_L: next_rdata = aux_gain[7:0]; // RULE19
      `ACSR_ADDR_AUX_GN_H: next_rdata = aux_gain[15:8]; // RULE19
      default: next_rdata = `ACSR_RST_BYTE;
    endcase
  end

  // read data and status mirror are registered to keep outputs glitch free
  always @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      sfr_rdata_o <= `ACSR_RST_BYTE;
      converter_status_o <= `ACSR_RST_STATUS;
    end
    else if (ce_i)
    begin
      if (sfr_rd_i)
      begin
        sfr_rdata_o <= next_rdata;
      end
      converter_status_o <= status_value;
    end
  end

endmodule

/* File: testbench/acsr_status_regs_assertions.sv */
// Purpose: port-level checks of the converter status register block
// Assumes: status output trails the internal flags by one cycle
// Notes: completions never coincide with operation writes in the bench
`timescale 1ns/1ns
`include "acsr_defines.vh"
module acsr_status_chk
(
  // clock and reset
  input wire sys_clk_i,
  input wire reset_n_i,
  input wire ce_i,
  // register port
  input wire [7:0] sfr_addr_i,
  input wire sfr_wr_i,
  input wire [7:0] sfr_wdata_i,
  // completions and reference
  input wire pri_conv_done_i,
  input wire pri_cal_done_i,
  input wire aux_conv_done_i,
  input wire aux_cal_done_i,
  input wire ref_missing_i,
  // outputs
  input wire pri_enable_o,
  input wire aux_enable_o,
  input wire pri_start_o,
  input wire aux_start_o,
  input wire chop_off_o,
  input wire [2:0] operation_select_o,
  input wire [7:0] decimation_o,
  input wire [7:0] converter_status_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  wire op_wr = ce_i && sfr_wr_i && sfr_addr_i == `ACSR_ADDR_OPER;
  wire any_done = pri_conv_done_i || pri_cal_done_i || aux_conv_done_i || aux_cal_done_i;
  property p_pri_rdy;
    ce_i && (pri_conv_done_i || pri_cal_done_i) && !sfr_wr_i |-> ##2 converter_status_o[7];
  endproperty
  a_pri_rdy: assert property (p_pri_rdy) else $error("primary ready not raised");
  property p_aux_rdy;
    ce_i && aux_conv_done_i && !sfr_wr_i |-> ##2 converter_status_o[6];
  endproperty
  a_aux_rdy: assert property (p_aux_rdy) else $error("aux ready not raised");
  property p_unimpl;
    converter_status_o[1:0] == 2'b00;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("status low bits not zero");
  property p_cal_clr_rdy;
    op_wr && sfr_wdata_i[2] && !any_done |-> ##2 !converter_status_o[7];
  endproperty
  a_cal_clr_rdy: assert property (p_cal_clr_rdy) else $error("ready kept after cal write");
  property p_op_clr;
    op_wr && (sfr_wdata_i[2] || sfr_wdata_i[1]) && !any_done
      |-> ##2 !converter_status_o[5] && !converter_status_o[3] && !converter_status_o[2];
  endproperty
  a_op_clr: assert property (p_op_clr) else $error("flags kept after start write");
  property p_enable;
    op_wr |=> pri_enable_o == $past(sfr_wdata_i[5]) && pri_start_o == $past(sfr_wdata_i[5]);
  endproperty
  a_enable: assert property (p_enable) else $error("primary enable mismatch");
  property p_oper_out;
    op_wr |=> aux_enable_o == $past(sfr_wdata_i[`ACSR_BIT_AUX_ON])
      && aux_start_o == $past(sfr_wdata_i[`ACSR_BIT_AUX_ON])
      && chop_off_o == $past(sfr_wdata_i[`ACSR_BIT_CHOP_OFF])
      && operation_select_o == $past(sfr_wdata_i[`ACSR_OP_MSB:`ACSR_OP_LSB]);
  endproperty
  a_oper_out: assert property (p_oper_out) else $error("operation outputs mismatch");
  // start is a one-cycle pulse unless another operation write follows at once
  property p_start_pulse;
    pri_start_o && !op_wr |=> !pri_start_o;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("primary start longer than a cycle");
  property p_ref_set;
    ((pri_enable_o || aux_enable_o) && ref_missing_i)[*8] |-> converter_status_o[4];
  endproperty
  a_ref_set: assert property (p_ref_set) else $error("missing reference not flagged");
  property p_ref_clr;
    (!ref_missing_i)[*8] |-> !converter_status_o[4];
  endproperty
  a_ref_clr: assert property (p_ref_clr) else $error("reference flag stuck");
  property p_decim;
    ce_i && sfr_wr_i && sfr_addr_i == `ACSR_ADDR_DECIM |=> decimation_o == $past(sfr_wdata_i);
  endproperty
  a_decim: assert property (p_decim) else $error("decimation not stored");
  c_start: cover property (pri_start_o);
  c_ref: cover property (converter_status_o[4]);
  c_err: cover property (converter_status_o[3] && converter_status_o[2]);
endmodule

/* File: testbench/acsr_core_model.sv */
// Purpose: processor core side of the register port
// Assumes: one access at a time, two cycles each
// Notes: released lines carry the inverse so stale values never match
`timescale 1ns/1ns
module acsr_core_model
(
  // clock
  input wire sys_clk_i,
  // register port
  output logic [7:0] sfr_addr_o,
  output logic sfr_wr_o,
  output logic [7:0] sfr_wdata_o,
  output logic sfr_rd_o
);
  initial
  begin
    sfr_addr_o = 8'h00;
    sfr_wr_o = 1'b0;
    sfr_wdata_o = 8'h00;
    sfr_rd_o = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    sfr_addr_o <= a;
    sfr_wdata_o <= d;
    sfr_wr_o <= 1'b1;
    @(posedge sys_clk_i);
    sfr_wr_o <= 1'b0;
    sfr_wdata_o <= ~d;
    sfr_addr_o <= ~a;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk_i);
    sfr_addr_o <= a;
    sfr_rd_o <= 1'b1;
    @(posedge sys_clk_i);
    sfr_rd_o <= 1'b0;
    sfr_addr_o <= ~a;
  endtask
endmodule

/* File: testbench/tb.sv */
// Purpose: self-checking bench for the converter status register block
// Assumes: clock enable dropped once to show that it freezes state
// Notes: reads queue their expected byte, a monitor compares it a cycle later
`timescale 1ns/1ns
`include "acsr_defines.vh"
module tb;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic ref_missing_i = 1'b0;
  logic [3:0] dn = 4'h0;
  logic cal_ok = 1'b0;
  logic cal_gain = 1'b0;
  logic [23:0] dat = 24'h0;
  logic [23:0] x;
  logic [7:0] r;
  logic [7:0] exp_q[$];
  logic rd_seen = 1'b0;
  logic ce = 1'b1;
  int checks = 0;
  int n_errors = 0;
  wire [7:0] sfr_addr_i;
  wire sfr_wr_i;
  wire [7:0] sfr_wdata_i;
  wire sfr_rd_i;
  wire [7:0] sfr_rdata_o;
  wire [7:0] decimation_o;
  wire [7:0] aux_control_o;
  always #4 sys_clk_i = ~sys_clk_i;
  acsr_core_model core (.sys_clk_i(sys_clk_i), .sfr_addr_o(sfr_addr_i), .sfr_wr_o(sfr_wr_i),
    .sfr_wdata_o(sfr_wdata_i), .sfr_rd_o(sfr_rd_i));
  acsr_status_regs DUT (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .ce_i(ce),
    .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rd_i(sfr_rd_i),
    .sfr_rdata_o(sfr_rdata_o), .ref_missing_i(ref_missing_i),
    .pri_conv_done_i(dn[3]), .pri_conv_data_i(dat), .pri_cal_done_i(dn[2]), .pri_cal_ok_i(cal_ok),
    .pri_cal_gain_i(cal_gain), .pri_cal_coeff_i(dat), .aux_conv_done_i(dn[1]), .aux_conv_data_i(dat),
    .aux_cal_done_i(dn[0]), .aux_cal_ok_i(cal_ok), .aux_cal_gain_i(cal_gain),
    .aux_cal_coeff_i(dat[15:0]), .pri_enable_o(), .aux_enable_o(), .pri_start_o(), .aux_start_o(),
    .chop_off_o(), .operation_select_o(), .decimation_o(decimation_o), .aux_control_o(aux_control_o),
    .converter_status_o());
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic rdx(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    core.rd(a);
  endtask
  // k: 0 pri conv, 1 pri cal, 2 aux conv, 3 aux cal
  task automatic done(input logic [1:0] k, input logic ok, input logic g, input logic [23:0] d);
    @(posedge sys_clk_i);
    dn <= 4'b1000 >> k;
    dat <= d;
    cal_ok <= ok;
    cal_gain <= g;
    @(posedge sys_clk_i);
    dn <= 4'b0000;
    dat <= ~d;
  endtask
  always @(posedge sys_clk_i)
  begin
    if (rd_seen)
      check("read data", sfr_rdata_o, exp_q.pop_front());
    rd_seen <= sfr_rd_i;
  end
  initial
  begin
    repeat (2000) @(posedge sys_clk_i);
    n_errors++;
    report_and_stop();
  end
  initial
  begin
    void'($urandom(48240));
    repeat (10) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    rdx(`ACSR_ADDR_STATUS, 8'h00);
    rdx(`ACSR_ADDR_OPER, 8'h08);
    rdx(`ACSR_ADDR_DECIM, 8'h45);
    rdx(8'h00, 8'h00);
    core.wr(`ACSR_ADDR_STATUS, 8'hff);
    rdx(`ACSR_ADDR_STATUS, 8'hc0);
    done(0, 1, 0, 24'h123456);
    rdx(8'hdb, 8'h00);
    core.wr(`ACSR_ADDR_STATUS, 8'h00);
    x = 24'($urandom) & 24'hfffffc | 24'h1;
    done(0, 1, 0, x);
    rdx(`ACSR_ADDR_STATUS, 8'h80);
    rdx(8'hd9, x[7:0]);
    rdx(8'hda, x[15:8]);
    rdx(8'hdb, x[23:16]);
    core.wr(`ACSR_ADDR_STATUS, 8'h00);
    fork
      core.wr(`ACSR_ADDR_STATUS, 8'h00);
      done(0, 1, 0, 24'hffffff);
    join
    rdx(`ACSR_ADDR_STATUS, 8'h88);
    rdx(8'hdb, 8'hff);
    core.wr(`ACSR_ADDR_OPER, 8'h26);
    rdx(`ACSR_ADDR_STATUS, 8'h00);
    x = 24'($urandom);
    done(1, 1, 0, x);
    rdx(`ACSR_ADDR_STATUS, 8'ha0);
    rdx(8'he1, x[7:0]);
    rdx(8'he2, x[15:8]);
    rdx(8'he3, x[23:16]);
    core.wr(`ACSR_ADDR_OPER, 8'h27);
    rdx(`ACSR_ADDR_STATUS, 8'h00);
    done(1, 0, 1, 24'h5a5a5a);
    rdx(`ACSR_ADDR_STATUS, 8'ha8);
    rdx(8'he6, 8'h00);
    core.wr(`ACSR_ADDR_OPER, 8'h22);
    rdx(`ACSR_ADDR_STATUS, 8'h80);
    core.wr(`ACSR_ADDR_STATUS, 8'h00);
    core.wr(`ACSR_ADDR_AUX_CTL, 8'h20);
    @(posedge sys_clk_i);
    check("aux control", aux_control_o, 8'h20);
    rdx(`ACSR_ADDR_AUX_CTL, 8'h20);
    core.wr(`ACSR_ADDR_OPER, 8'h14);
    done(3, 1, 1, 24'h00c3a5);
    rdx(`ACSR_ADDR_STATUS, 8'h00);
    core.wr(`ACSR_ADDR_AUX_CTL, 8'h00);
    done(3, 1, 1, 24'h00c3a5);
    rdx(`ACSR_ADDR_STATUS, 8'h60);
    rdx(8'heb, 8'ha5);
    rdx(8'hec, 8'hc3);
    core.wr(`ACSR_ADDR_STATUS, 8'h00);
    done(2, 1, 0, 24'hffffff);
    rdx(`ACSR_ADDR_STATUS, 8'h64);
    rdx(8'hde, 8'hff);
    core.wr(`ACSR_ADDR_STATUS, 8'h00);
    ref_missing_i <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    rdx(`ACSR_ADDR_STATUS, 8'h34);
    done(0, 1, 0, 24'h012345);
    rdx(8'hd9, 8'hff);
    rdx(`ACSR_ADDR_STATUS, 8'hbc);
    ref_missing_i <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
    rdx(`ACSR_ADDR_STATUS, 8'hac);
    r = 8'($urandom);
    core.wr(`ACSR_ADDR_DECIM, r);
    @(posedge sys_clk_i);
    check("decimation", decimation_o, r);
    // a write while the enable is low must leave every register as it was
    ce <= 1'b0;
    core.wr(`ACSR_ADDR_DECIM, ~r);
    ce <= 1'b1;
    @(posedge sys_clk_i);
    check("frozen decimation", decimation_o, r);
    rdx(`ACSR_ADDR_DECIM, r);
    repeat (3) @(posedge sys_clk_i);
    check("pending reads", 8'(exp_q.size()), 8'h00);
    report_and_stop();
  end
endmodule
bind acsr_status_regs acsr_status_chk u_chk (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
  .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i),
  .pri_conv_done_i(pri_conv_done_i), .pri_cal_done_i(pri_cal_done_i), .aux_conv_done_i(aux_conv_done_i),
  .aux_cal_done_i(aux_cal_done_i), .ref_missing_i(ref_missing_i), .pri_enable_o(pri_enable_o),
  .aux_enable_o(aux_enable_o), .pri_start_o(pri_start_o), .aux_start_o(aux_start_o), .chop_off_o(chop_off_o),
  .operation_select_o(operation_select_o), .decimation_o(decimation_o),
  .converter_status_o(converter_status_o));
